// ---- hw/arcc_ctrl.v ----
// Purpose : gain, reference choice, reference check, result coding
// Assumes : analog comparators and modulator deliver synchronous levels
// Notes   : APB slave; one level interrupt from sticky events
`timescale 1ns/10ps
`include "arcc_defs.vh"

// Contract
// - gains 1, 8, 16, 32, 64, 128 chosen by a 3-bit gain code
// - one config bit chooses which reference pair is used
// - choice bit 1 makes second pair reference, else two outputs
// - reference check runs only while its enable bit is 1
// - flag set when selected reference is below 0.3 V
// - flag cleared above 0.6 V; between thresholds undefined
// - while flag active, conversion result forced to all ones
// - flag during calibration blocks coefficient update
// - calibration aborted by missing reference sets error flag
// - polarity bit selects unipolar or bipolar coding
// - unipolar: straight binary, zero input gives zeros
// - bipolar: offset binary, zero input gives one then zeros
// - result word is 24 bits wide
// - one enable switches both check currents onto selected pair
module arcc_ctrl #(
  parameter DW = 24
) (
  // clock and reset
  input  wire          REF_CLK,
  input  wire          RESET_N,
  // apb slave
  input  wire [11:0]   PADDR,
  input  wire          PSEL,
  input  wire          PENABLE,
  input  wire          PWRITE,
  input  wire [31:0]   PWDATA,
  output reg  [31:0]   PRDATA,
  output reg           PREADY,
  output reg           PSLVERR,
  // modulator result, signed two's complement
  input  wire [DW-1:0] RAW_DATA,
  input  wire          RAW_VALID,
  // calibration sequencer
  input  wire          CAL_ACTIVE,
  input  wire          CAL_KIND,
  input  wire [DW-1:0] CAL_COEF,
  input  wire          CAL_DONE,
  // reference comparators, per pair: below low, above high
  input  wire          REF1_BELOW_LOW,
  input  wire          REF1_ABOVE_HIGH,
  input  wire          REF2_BELOW_LOW,
  input  wire          REF2_ABOVE_HIGH,
  // analog controls
  output reg  [7:0]    GAIN_SETTING,
  output reg           REF_SECOND_SEL,
  output reg           REF2_AS_OUTPUT,
  output reg  [1:0]    GPO_LEVEL,
  output reg           BURN_ENABLE,
  // interrupt
  output reg           IRQ
);

  reg  [`ARCC_CFG_W-1:0] cfg_r;
  reg  [DW-1:0]          data_r;
  reg  [DW-1:0]          offs_r;
  reg  [DW-1:0]          fsc_r;
  reg                    err_r;
  reg                    rdy_r;
  reg                    cal_hit_r;
  reg  [`ARCC_EV_W-1:0]  irq_st_r;
  reg  [`ARCC_EV_W-1:0]  irq_mask_r;
  reg                    reference_missing_flag_r;
  reg                    reference_missing_flag_nxt;
  reg  [7:0]             gain_nxt;
  reg                    gain_bad;
  reg  [DW-1:0]          coded;
  reg  [`ARCC_EV_W-1:0]  ev;
  reg  [31:0]            rd_nxt;
  reg                    hit;
  wire                   wr_en;
  wire                   rd_en;
  wire                   low_sel;
  wire                   high_sel;
  wire                   low_f;
  wire                   high_f;
  wire [2:0]             gcode;
  wire                   acc_first;
  wire                   sel_cfg;
  wire                   sel_irq;
  wire                   sel_mask;
  wire                   sel_data;
  wire                   sel_offs;
  wire                   sel_fsc;
  wire                   cal_end;
  wire [`ARCC_EV_W-1:0]  irq_clr;

  //----------------------------------------------------------------
  // apb decode
  //----------------------------------------------------------------
  // only the first access edge acts, so a write lands once
  assign acc_first = PSEL & PENABLE & ~PREADY;
  assign wr_en     = acc_first & PWRITE;
  assign rd_en     = acc_first & ~PWRITE;
  assign sel_cfg   = (PADDR == `ARCC_CFG_OFF);
  assign sel_irq   = (PADDR == `ARCC_IRQ_OFF);
  assign sel_mask  = (PADDR == `ARCC_MASK_OFF);
  assign sel_data  = (PADDR == `ARCC_DATA_OFF);
  assign sel_offs  = (PADDR == `ARCC_OFFS_OFF);
  assign sel_fsc   = (PADDR == `ARCC_FSC_OFF);
  assign irq_clr   = (wr_en & sel_irq) ? PWDATA[`ARCC_EV_W-1:0]
                                        : {`ARCC_EV_W{1'b0}};
  assign cal_end   = CAL_ACTIVE & CAL_DONE;
  assign gcode     = cfg_r[`ARCC_CFG_GAIN_HI:`ARCC_CFG_GAIN_LO];

  //----------------------------------------------------------------
  // gain table
  //----------------------------------------------------------------
  always @* begin
    gain_bad = 1'b0;
    case (gcode)
      3'h0:    gain_nxt = 8'h01;
      3'h3:    gain_nxt = 8'h08;
      3'h4:    gain_nxt = 8'h10;
      3'h5:    gain_nxt = 8'h20;
      3'h6:    gain_nxt = 8'h40;
      3'h7:    gain_nxt = 8'h80;
      default: begin
        gain_nxt = 8'h01;
        gain_bad = 1'b1;
      end
    endcase
  end

  //----------------------------------------------------------------
  // reference detect with hysteresis
  //----------------------------------------------------------------
  // comparators of the pair in use
  assign low_sel  = cfg_r[`ARCC_CFG_REFCH] ? REF2_BELOW_LOW
                                           : REF1_BELOW_LOW;
  assign high_sel = cfg_r[`ARCC_CFG_REFCH] ? REF2_ABOVE_HIGH
                                           : REF1_ABOVE_HIGH;

  arcc_level_filter #(
    .COUNT (`ARCC_SETTLE_CYC),
    .CW    (8)
  ) u_low_filt (
    .clk       (REF_CLK),
    .rst_n     (RESET_N),
    .enable    (cfg_r[`ARCC_CFG_REFCHK]),
    .level_in  (low_sel),
    .level_out (low_f)
  );

  arcc_level_filter #(
    .COUNT (`ARCC_SETTLE_CYC),
    .CW    (8)
  ) u_high_filt (
    .clk       (REF_CLK),
    .rst_n     (RESET_N),
    .enable    (cfg_r[`ARCC_CFG_REFCHK]),
    .level_in  (high_sel),
    .level_out (high_f)
  );

  always @* begin
    reference_missing_flag_nxt = reference_missing_flag_r;
    if (!cfg_r[`ARCC_CFG_REFCHK])
      reference_missing_flag_nxt = 1'b0;
    else if (low_f)
      reference_missing_flag_nxt = 1'b1;
    else if (high_f)
      reference_missing_flag_nxt = 1'b0;
  end

  //----------------------------------------------------------------
  // output coding
  //----------------------------------------------------------------
  always @* begin
    if (reference_missing_flag_r)
      coded = {DW{1'b1}};
    else if (cfg_r[`ARCC_CFG_UNIPOL])
      coded = RAW_DATA[DW-1] ? {DW{1'b0}}
                             : {RAW_DATA[DW-2:0], 1'b0};
    else
      coded = {~RAW_DATA[DW-1], RAW_DATA[DW-2:0]};
  end

  //----------------------------------------------------------------
  // events
  //----------------------------------------------------------------
  always @* begin
    ev = {`ARCC_EV_W{1'b0}};
    ev[`ARCC_EV_DONE]   = RAW_VALID & ~CAL_ACTIVE;
    ev[`ARCC_EV_REFERENCE_MISSING_FLAG]  = reference_missing_flag_nxt & ~reference_missing_flag_r;
    ev[`ARCC_EV_CALERR] = cal_end & (cal_hit_r | reference_missing_flag_r);
  end

  //----------------------------------------------------------------
  // state and registers
  //----------------------------------------------------------------
  // configuration and interrupt mask
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_r      <= `ARCC_CFG_RST;
      irq_mask_r <= {`ARCC_EV_W{1'b0}};
    end else begin
      if (wr_en && sel_cfg)
        cfg_r <= PWDATA[`ARCC_CFG_W-1:0];
      if (wr_en && sel_mask)
        irq_mask_r <= PWDATA[`ARCC_EV_W-1:0];
    end
  end

  // reference flag and sticky interrupt status
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reference_missing_flag_r  <= 1'b0;
      irq_st_r <= {`ARCC_EV_W{1'b0}};
    end else begin
      reference_missing_flag_r  <= reference_missing_flag_nxt;
      // set wins over write-one-to-clear
      irq_st_r <= (irq_st_r & ~irq_clr) | ev;
    end
  end

  // result register; a new result beats the clearing read
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_r <= {DW{1'b0}};
      rdy_r  <= 1'b0;
    end else if (RAW_VALID && !CAL_ACTIVE) begin
      data_r <= coded;
      rdy_r  <= 1'b1;
    end else if (rd_en && sel_data) begin
      rdy_r <= 1'b0;
    end
  end

  // calibration coefficients and error flag
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      offs_r    <= `ARCC_OFFS_RST;
      fsc_r     <= `ARCC_FSC_RST;
      err_r     <= 1'b0;
      cal_hit_r <= 1'b0;
    end else begin
      // remember any missing reference seen in a calibration
      if (!CAL_ACTIVE)
        cal_hit_r <= 1'b0;
      else if (reference_missing_flag_r)
        cal_hit_r <= 1'b1;
      if (cal_end) begin
        if (cal_hit_r || reference_missing_flag_r) begin
          err_r <= 1'b1;
        end else begin
          err_r <= 1'b0;
          if (CAL_KIND == `ARCC_CAL_OFFSET)
            offs_r <= CAL_COEF;
          else
            fsc_r  <= CAL_COEF;
        end
      end else if (wr_en && sel_offs) begin
        offs_r <= PWDATA[DW-1:0];
      end else if (wr_en && sel_fsc) begin
        fsc_r <= PWDATA[DW-1:0];
      end
    end
  end

  //----------------------------------------------------------------
  // apb read and answer
  //----------------------------------------------------------------
  always @* begin
    rd_nxt = 32'h00000000;
    hit    = 1'b1;
    case (PADDR)
      `ARCC_CFG_OFF:  rd_nxt[`ARCC_CFG_W-1:0] = cfg_r;
      `ARCC_STAT_OFF: begin
        rd_nxt[`ARCC_ST_REFERENCE_MISSING_FLAG]   = reference_missing_flag_r;
        rd_nxt[`ARCC_ST_ERR]     = err_r;
        rd_nxt[`ARCC_ST_RDY]     = rdy_r;
        rd_nxt[`ARCC_ST_GAINBAD] = gain_bad;
      end
      `ARCC_IRQ_OFF:  rd_nxt[`ARCC_EV_W-1:0] = irq_st_r;
      `ARCC_MASK_OFF: rd_nxt[`ARCC_EV_W-1:0] = irq_mask_r;
      `ARCC_DATA_OFF: rd_nxt[DW-1:0] = data_r;
      `ARCC_OFFS_OFF: rd_nxt[DW-1:0] = offs_r;
      `ARCC_FSC_OFF:  rd_nxt[DW-1:0] = fsc_r;
      `ARCC_GAIN_OFF: rd_nxt[7:0] = gain_nxt;
      default:        hit = 1'b0;
    endcase
  end

  // single wait state: answer in the first access cycle's next edge
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PRDATA  <= PWRITE ? 32'h00000000 : rd_nxt;
      PREADY  <= 1'b1;
      PSLVERR <= ~hit;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // analog control outputs and interrupt
  //----------------------------------------------------------------
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GAIN_SETTING   <= 8'h01;
      REF_SECOND_SEL <= 1'b0;
      REF2_AS_OUTPUT <= 1'b1;
      GPO_LEVEL      <= 2'h0;
      BURN_ENABLE    <= 1'b0;
      IRQ            <= 1'b0;
    end else begin
      GAIN_SETTING   <= gain_nxt;
      REF_SECOND_SEL <= cfg_r[`ARCC_CFG_REFCH];
      REF2_AS_OUTPUT <= ~cfg_r[`ARCC_CFG_REFCH];
      GPO_LEVEL      <= cfg_r[`ARCC_CFG_REFCH] ? 2'h0 :
                        {cfg_r[`ARCC_CFG_GPO1],
                         cfg_r[`ARCC_CFG_GPO0]};
      BURN_ENABLE    <= cfg_r[`ARCC_CFG_BURN];
      IRQ            <= |(irq_st_r & irq_mask_r);
    end
  end

endmodule

// ---- common/arcc_defs.vh ----
// Purpose : constants for the converter reference and coding control block
// Assumes : APB word-aligned register map, 100 MHz REF_CLK
// Notes   : included by the control block and its level filter
`ifndef ARCC_DEFS_VH
`define ARCC_DEFS_VH

// register byte offsets
`define ARCC_CFG_OFF      12'h000
`define ARCC_STAT_OFF     12'h004
`define ARCC_IRQ_OFF      12'h008
`define ARCC_MASK_OFF     12'h00C
`define ARCC_DATA_OFF     12'h010
`define ARCC_OFFS_OFF     12'h014
`define ARCC_FSC_OFF      12'h018
`define ARCC_GAIN_OFF     12'h01C

// configuration fields
`define ARCC_CFG_GAIN_LO  0
`define ARCC_CFG_GAIN_HI  2
`define ARCC_CFG_REFCH    3
`define ARCC_CFG_REFCHK   4
`define ARCC_CFG_UNIPOL   5
`define ARCC_CFG_BURN     6
`define ARCC_CFG_GPO0     7
`define ARCC_CFG_GPO1     8
`define ARCC_CFG_W        9
`define ARCC_CFG_RST      9'h000

// status bits
`define ARCC_ST_REFERENCE_MISSING_FLAG     0
`define ARCC_ST_ERR       1
`define ARCC_ST_RDY       2
`define ARCC_ST_GAINBAD   3

// interrupt event bits
`define ARCC_EV_DONE      0
`define ARCC_EV_REFERENCE_MISSING_FLAG     1
`define ARCC_EV_CALERR    2
`define ARCC_EV_W         3

// calibration coefficient reset values
`define ARCC_OFFS_RST     24'h800000
`define ARCC_FSC_RST      24'h500000

// calibration kinds on CAL_KIND
`define ARCC_CAL_OFFSET   1'b0
`define ARCC_CAL_FULL     1'b1

// detector input settling time and filter count
`define ARCC_SETTLE_NS    100
`define ARCC_CLK_NS       10
`define ARCC_SETTLE_CYC   ((`ARCC_SETTLE_NS + `ARCC_CLK_NS - 1) / `ARCC_CLK_NS)

`endif

// ---- hw/arcc_level_filter.v ----
// Purpose : debounce of a comparator level into a stable flag
// Assumes : input synchronous to clk
// Notes   : flag follows input after COUNT equal samples
`timescale 1ns/10ps
`include "arcc_defs.vh"

module arcc_level_filter #(
  parameter COUNT = `ARCC_SETTLE_CYC,
  parameter CW    = 8
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level
  input  wire enable,
  input  wire level_in,
  output reg  level_out
);

  reg [CW-1:0] cnt_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= {CW{1'b0}};
      level_out <= 1'b0;
    end else if (!enable) begin
      cnt_r     <= {CW{1'b0}};
      level_out <= 1'b0;
    end else if (level_in == level_out) begin
      cnt_r <= {CW{1'b0}};
    end else if (cnt_r == COUNT[CW-1:0] - 1'b1) begin
      cnt_r     <= {CW{1'b0}};
      level_out <= level_in;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

// ---- verification/arcc_ctrl_chk.sv ----
// Purpose: port checks for the reference and coding control block
// Assumes: bound to arcc_ctrl, one clock domain
// Notes: configuration tracked from apb writes seen at the pins
`timescale 1ns/10ps
`include "arcc_defs.vh"
module arcc_ctrl_chk (
  // clock and reset
  input wire        REF_CLK,
  input wire        RESET_N,
  // apb
  input wire [11:0] PADDR,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [31:0] PWDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // analog controls
  input wire [7:0]  GAIN_SETTING,
  input wire        REF_SECOND_SEL,
  input wire        REF2_AS_OUTPUT,
  input wire [1:0]  GPO_LEVEL,
  input wire        BURN_ENABLE
);
  logic [8:0] cfg_w;
  wire        wr_acc = PSEL && PENABLE && PWRITE && !PREADY;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------
  // last configuration written
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      cfg_w <= `ARCC_CFG_RST;
    else if (wr_acc && PADDR == `ARCC_CFG_OFF)
      cfg_w <= PWDATA[8:0];
  end
  sequence s_cfg_wr;
    wr_acc && PADDR == `ARCC_CFG_OFF;
  endsequence
  sequence s_acc2;
    s_cfg_wr ##2 1'b1;
  endsequence
  property p_sel;
    s_acc2 |-> REF_SECOND_SEL == cfg_w[`ARCC_CFG_REFCH];
  endproperty
  property p_out;
    REF2_AS_OUTPUT != REF_SECOND_SEL;
  endproperty
  property p_gpo;
    s_acc2 |-> GPO_LEVEL == (cfg_w[3] ? 2'h0 : cfg_w[8:7]);
  endproperty
  property p_quiet;
    REF_SECOND_SEL |-> GPO_LEVEL == 2'h0;
  endproperty
  property p_burn;
    s_acc2 |-> BURN_ENABLE == cfg_w[`ARCC_CFG_BURN];
  endproperty
  property p_hold;
    $changed(BURN_ENABLE) |-> $past(wr_acc) || $past(wr_acc, 2);
  endproperty
  property p_gain;
    s_acc2 |-> GAIN_SETTING ==
      (cfg_w[2:0] < 3'h3 ? 8'h01 : 8'h01 << cfg_w[2:0]);
  endproperty
  property p_gset;
    GAIN_SETTING inside {8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  endproperty
  property p_slv;
    PSLVERR |-> PREADY;
  endproperty
  a_sel: assert property (p_sel)
    else $error("reference choice differs from config");
  a_out: assert property (p_out)
    else $error("second pair both reference and output");
  a_gpo: assert property (p_gpo)
    else $error("output pin levels differ from config");
  a_quiet: assert property (p_quiet)
    else $error("output pins driven while reference");
  a_burn: assert property (p_burn)
    else $error("check currents differ from config");
  a_hold: assert property (p_hold)
    else $error("check currents changed without a write");
  a_gain: assert property (p_gain)
    else $error("gain value does not follow gain code");
  a_gset: assert property (p_gset)
    else $error("unsupported gain value");
  a_slv: assert property (p_slv)
    else $error("error response without ready");
endmodule

// ---- verification/arcc_ref_src.sv ----
// Purpose: external reference source seen through its comparators
// Assumes: pair voltages in millivolts set by the bench
// Notes: between the thresholds neither comparator is high
`timescale 1ns/10ps
module arcc_ref_src (
  // reference voltages in mV
  input wire [12:0] ref1_mv,
  input wire [12:0] ref2_mv,
  // comparator levels
  output wire       ref1_low,
  output wire       ref1_high,
  output wire       ref2_low,
  output wire       ref2_high
);
  assign ref1_low  = ref1_mv < 13'h12C;
  assign ref1_high = ref1_mv > 13'h258;
  assign ref2_low  = ref2_mv < 13'h12C;
  assign ref2_high = ref2_mv > 13'h258;
endmodule

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the reference and coding control
// Assumes: apb master in the bench, reference source model
// Notes: read results checked from a queue of expected values
`timescale 1ns/10ps
`include "arcc_defs.vh"
module tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        raw_v, cal_a, cal_k, cal_d, r1l, r1h, r2l, r2h;
  logic        rsel, r2o, burn, irq;
  logic [1:0]  gpo;
  logic [7:0]  gain;
  logic [11:0] paddr;
  logic [12:0] mv1, mv2;
  logic [23:0] raw, cal_c, v;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          fails, n_compared, cyc, i;
  arcc_ctrl #(.DW(24)) dut_u (.REF_CLK(clk), .RESET_N(rst_n),
    .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RAW_DATA(raw), .RAW_VALID(raw_v),
    .CAL_ACTIVE(cal_a), .CAL_KIND(cal_k), .CAL_COEF(cal_c),
    .CAL_DONE(cal_d), .REF1_BELOW_LOW(r1l), .REF1_ABOVE_HIGH(r1h),
    .REF2_BELOW_LOW(r2l), .REF2_ABOVE_HIGH(r2h), .GAIN_SETTING(gain),
    .REF_SECOND_SEL(rsel), .REF2_AS_OUTPUT(r2o), .GPO_LEVEL(gpo),
    .BURN_ENABLE(burn), .IRQ(irq));
  arcc_ref_src ref_u (.ref1_mv(mv1), .ref2_mv(mv2), .ref1_low(r1l),
    .ref1_high(r1h), .ref2_low(r2l), .ref2_high(r2h));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // bus, stimulus and compare tasks
  // ----------------------------------------
  task automatic xfer(input [11:0] a, input [31:0] d, input w);
    @(posedge clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input [11:0] a, input [32:0] e);
    exp_q.push_back(e);
    xfer(a, 32'h0, 1'b0);
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(a, d, 1'b1);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic raw_in(input [23:0] d);
    @(posedge clk);
    raw   <= d;
    raw_v <= 1'b1;
    @(posedge clk);
    raw_v <= 1'b0;
  endtask
  task automatic cal(input k, input [23:0] c, input drop);
    @(posedge clk);
    cal_a <= 1'b1;
    cal_k <= k;
    cal_c <= c;
    if (drop)
      mv1 <= 13'h064;
    wt(14);
    cal_d <= 1'b1;
    @(posedge clk);
    cal_d <= 1'b0;
    cal_a <= 1'b0;
  endtask
  task automatic cmp(input [32:0] got, input [32:0] e);
    n_compared++;
    if (got !== e) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
    if (pready === 1'b1 && pwrite === 1'b0)
      cmp({pslverr, prdata}, exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, raw_v, cal_a, cal_k, cal_d} = 7'h00;
    {paddr, pwdata, raw, cal_c} = 92'h0;
    {mv1, mv2} = {13'h9C4, 13'h9C4};
    {rst_n, fails, n_compared, cyc} = 0;
    void'($urandom(55794));
    wt(10);
    rst_n <= 1'b1;
    rd(`ARCC_CFG_OFF, 33'h0);
    rd(`ARCC_OFFS_OFF, 33'h800000);
    rd(`ARCC_FSC_OFF, 33'h500000);
    rd(`ARCC_GAIN_OFF, 33'h1);
    rd(12'h020, 33'h100000000);
    for (i = 0; i < 8; i++) begin
      v = ($urandom & 24'h0001C8) | i;
      wr(`ARCC_CFG_OFF, v);
      rd(`ARCC_CFG_OFF, v);
      rd(`ARCC_GAIN_OFF, i < 3 ? 33'h1 : 33'h1 << i);
      rd(`ARCC_STAT_OFF, (i == 1 || i == 2) ? 33'h8 : 33'h0);
    end
    for (i = 0; i < 8; i++) begin
      v = i == 0 ? 24'h7FFFFF : i == 1 ? 24'h800000 : $urandom;
      v = i == 2 ? 24'h000000 : v;
      wr(`ARCC_CFG_OFF, i[0] << 5);
      raw_in(v);
      rd(`ARCC_DATA_OFF, i[0] ? (v[23] ? 24'h0 : {v[22:0], 1'b0})
                              : v ^ 24'h800000);
    end
    wr(`ARCC_CFG_OFF, 32'h010);
    mv1 <= 13'h064;
    wt(14);
    rd(`ARCC_STAT_OFF, 33'h1);
    raw_in(24'h123456);
    rd(`ARCC_DATA_OFF, 33'hFFFFFF);
    rd(`ARCC_STAT_OFF, 33'h1);
    wr(`ARCC_CFG_OFF, 32'h018);
    wt(14);
    rd(`ARCC_STAT_OFF, 33'h0);
    mv1 <= 13'h2BC;
    wr(`ARCC_CFG_OFF, 32'h010);
    wt(14);
    rd(`ARCC_STAT_OFF, 33'h0);
    mv1 <= 13'h064;
    wr(`ARCC_CFG_OFF, 32'h000);
    wt(14);
    rd(`ARCC_STAT_OFF, 33'h0);
    mv1 <= 13'h9C4;
    wr(`ARCC_CFG_OFF, 32'h010);
    wt(14);
    v = $urandom;
    cal(`ARCC_CAL_OFFSET, v, 1'b0);
    rd(`ARCC_OFFS_OFF, v);
    rd(`ARCC_STAT_OFF, 33'h0);
    cal(`ARCC_CAL_FULL, ~v, 1'b1);
    rd(`ARCC_FSC_OFF, 33'h500000);
    rd(`ARCC_STAT_OFF, 33'h3);
    rd(`ARCC_IRQ_OFF, 33'h7);
    cmp(irq, 33'h0);
    wr(`ARCC_MASK_OFF, 32'h4);
    wt(2);
    cmp(irq, 33'h1);
    wr(`ARCC_IRQ_OFF, 32'h4);
    wt(2);
    cmp(irq, 33'h0);
    rd(`ARCC_IRQ_OFF, 33'h3);
    wt(2);
    close_out;
  end
endmodule
bind arcc_ctrl arcc_ctrl_chk chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .GAIN_SETTING(GAIN_SETTING), .REF_SECOND_SEL(REF_SECOND_SEL),
  .REF2_AS_OUTPUT(REF2_AS_OUTPUT), .GPO_LEVEL(GPO_LEVEL),
  .BURN_ENABLE(BURN_ENABLE));
